// File: hdl/interval_timer_pkg.sv
/*
  Constants, register layout and types for the watchdog/interval timer.
  Assumes a 125 MHz system clock and an AXI4-Lite register bus.
*/
package interval_timer_pkg;
  localparam logic [15:0] CTRL_INDEX = 16'hffa8;
  localparam logic [15:0] COUNT_INDEX = 16'hffa9;
  localparam logic [15:0] STATUS_INDEX = 16'hffaa;
  localparam logic [7:0] PASS_COUNT = 8'h5a;
  localparam logic [7:0] PASS_CTRL = 8'ha5;
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam logic [7:0] STATUS_RESET = 8'h08;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [9:0] RESET_CYCLES = 10'h206;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] WORD_STRB = 4'h3;
  localparam int IND_BIT = 3;
  localparam int PASS_LSB = 8;
  localparam int FLAG_BIT = 7;

  typedef struct packed {
    logic overflow_flag;
    logic watchdog_mode_select;
    logic timer_run_enable;
    logic reserved_one;
    logic reset_action_select;
    logic [2:0] clock_divider_select;
  } ctrl_type;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_RESET = 1'b1
  } rst_state_type;

  // Mask of prescaler bits that must all be ones for a count pulse
  function automatic logic [11:0] divider_mask(input logic [2:0] sel);
    case (sel)
      3'h0: divider_mask = 12'h001;
      3'h1: divider_mask = 12'h01f;
      3'h2: divider_mask = 12'h03f;
      3'h3: divider_mask = 12'h07f;
      3'h4: divider_mask = 12'h0ff;
      3'h5: divider_mask = 12'h1ff;
      3'h6: divider_mask = 12'h7ff;
      default: divider_mask = 12'hfff;
    endcase
  endfunction
endpackage

// File: hdl/watchdog_interval_timer.sv
/*
  8-bit watchdog / interval timer with an AXI4-Lite register slave.
  Assumes one 125 MHz clock; standby recovery pulse comes from same-clock logic.
*/
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer
  import interval_timer_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic standby_recover,
  output logic chip_reset_req,
  output logic reset_output_pin_n,
  output logic nmi_req,
  output logic interval_overflow_request
);

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [15:0] aw_index_ff;
  logic [15:0] w_data_ff;
  logic [3:0] w_strb_ff;
  ctrl_type ctrl_ff;
  logic [7:0] watchdog_up_counter_ff;
  logic [11:0] div_cnt_ff;
  logic flag_seen_ff;
  logic external_reset_indicator_ff;
  rst_state_type rst_state_ff;
  logic [9:0] rst_cnt_ff;
  logic chip_reset_req_ff, reset_output_pin_n_ff, nmi_req_ff, irq_ff;

  logic wr_go, wr_hit, count_wr, ctrl_wr, tick, overflow, rst_active;
  logic [15:0] rd_index;
  logic [7:0] wr_byte;

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign chip_reset_req = chip_reset_req_ff;
  assign reset_output_pin_n = reset_output_pin_n_ff;
  assign nmi_req = nmi_req_ff;
  assign interval_overflow_request = irq_ff;

  // Write path: address and data taken in either order, answered together
  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_hit = wr_go && (aw_index_ff == CTRL_INDEX) && ((w_strb_ff & WORD_STRB) == WORD_STRB);
  assign wr_byte = w_data_ff[7:0];
  // Byte writes or a wrong password leave both registers untouched
  assign count_wr = wr_hit && (w_data_ff[15:PASS_LSB] == PASS_COUNT);
  assign ctrl_wr = wr_hit && (w_data_ff[15:PASS_LSB] == PASS_CTRL);
  assign rd_index = araddr[17:2];
  assign rst_active = (rst_state_ff == ST_RESET);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awready_ff <= 1'b1;
      aw_index_ff <= 16'h0000;
    end else if (awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_index_ff <= awaddr[17:2];
    end else if (bvalid_ff && bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wready_ff <= 1'b1;
      w_data_ff <= 16'h0000;
      w_strb_ff <= 4'h0;
    end else if (wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_data_ff <= wdata[15:0];
      w_strb_ff <= wstrb;
    end else if (bvalid_ff && bready) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (count_wr || ctrl_wr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read path: one cycle from address to data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      case (rd_index)
        CTRL_INDEX: rdata_ff <= {24'h000000, ctrl_ff};
        COUNT_INDEX: rdata_ff <= {24'h000000, watchdog_up_counter_ff};
        STATUS_INDEX: rdata_ff <= {28'h0000000, external_reset_indicator_ff, 3'h0};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Free-running prescaler; a count pulse when the selected low bits are all ones
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_ff <= 12'h000;
    end else begin
      div_cnt_ff <= div_cnt_ff + 12'h001;
    end
  end

  // Changing the select while running can skip or double a pulse
  assign tick = ((div_cnt_ff & divider_mask(ctrl_ff.clock_divider_select))
                 == divider_mask(ctrl_ff.clock_divider_select));

  assign overflow = ctrl_ff.timer_run_enable && tick && !count_wr && !rst_active
                    && (watchdog_up_counter_ff == CNT_MAX);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_up_counter_ff <= CNT_ZERO;
    end else if (rst_active || standby_recover) begin
      watchdog_up_counter_ff <= CNT_ZERO;
    end else if (count_wr) begin
      watchdog_up_counter_ff <= wr_byte;
    end else if (!ctrl_ff.timer_run_enable) begin
      watchdog_up_counter_ff <= CNT_ZERO;
    end else if (tick) begin
      watchdog_up_counter_ff <= watchdog_up_counter_ff + 8'h01;
    end
  end

  // Control/status; the hardware set of the flag beats a software clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (rst_active) begin
      ctrl_ff <= CTRL_RESET;
    end else if (standby_recover) begin
      ctrl_ff <= {CTRL_RESET[7:3], ctrl_ff.clock_divider_select};
    end else begin
      if (ctrl_wr) begin
        ctrl_ff.watchdog_mode_select <= wr_byte[6];
        ctrl_ff.timer_run_enable <= wr_byte[5];
        ctrl_ff.reset_action_select <= wr_byte[3];
        ctrl_ff.clock_divider_select <= wr_byte[2:0];
      end
      if (overflow) begin
        ctrl_ff.overflow_flag <= 1'b1;
      end else if (ctrl_wr && !wr_byte[FLAG_BIT] && flag_seen_ff) begin
        ctrl_ff.overflow_flag <= 1'b0;
      end
    end
  end

  // Remembers a read of the flag as 1, arming the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_seen_ff <= 1'b0;
    end else if (!ctrl_ff.overflow_flag) begin
      flag_seen_ff <= 1'b0;
    end else if (arvalid && arready_ff && (rd_index == CTRL_INDEX)) begin
      flag_seen_ff <= 1'b1;
    end
  end

  // Requests toward the CPU, registered with the flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmi_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      // Shares the NMI pin's vector downstream
      nmi_req_ff <= overflow && ctrl_ff.watchdog_mode_select && !ctrl_ff.reset_action_select;
      irq_ff <= overflow && !ctrl_ff.watchdog_mode_select;
    end
  end

  // Chip reset pulse; the pin follows it exactly
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_state_ff <= ST_RUN;
      rst_cnt_ff <= 10'h000;
      chip_reset_req_ff <= 1'b0;
      reset_output_pin_n_ff <= 1'b1;
    end else begin
      case (rst_state_ff)
        ST_RUN: begin
          if (overflow && ctrl_ff.watchdog_mode_select && ctrl_ff.reset_action_select) begin
            rst_state_ff <= ST_RESET;
            rst_cnt_ff <= RESET_CYCLES - 10'h001;
            chip_reset_req_ff <= 1'b1;
            reset_output_pin_n_ff <= 1'b0;
          end
        end
        ST_RESET: begin
          if (rst_cnt_ff == 10'h000) begin
            rst_state_ff <= ST_RUN;
            chip_reset_req_ff <= 1'b0;
            reset_output_pin_n_ff <= 1'b1;
          end else begin
            rst_cnt_ff <= rst_cnt_ff - 10'h001;
          end
        end
        default: begin
          rst_state_ff <= ST_RUN;
          chip_reset_req_ff <= 1'b0;
          reset_output_pin_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // Reset source: 1 after external reset, 0 after a watchdog reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      external_reset_indicator_ff <= STATUS_RESET[IND_BIT];
    end else if (overflow && ctrl_ff.watchdog_mode_select && ctrl_ff.reset_action_select) begin
      external_reset_indicator_ff <= 1'b0;
    end
  end

  // Helper: length of the current reset pulse
  logic [9:0] pulse_len_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_len_ff <= 10'h000;
    end else if (chip_reset_req_ff) begin
      pulse_len_ff <= pulse_len_ff + 10'h001;
    end else begin
      pulse_len_ff <= 10'h000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence wd_reset_fire;
    overflow && ctrl_ff.watchdog_mode_select && ctrl_ff.reset_action_select;
  endsequence

  sequence reset_started;
    chip_reset_req && !reset_output_pin_n && !external_reset_indicator_ff;
  endsequence

  a_reset_entry: assert property (wd_reset_fire |=> reset_started)
    else $error("watchdog reset not started");
  a_reset_length: assert property ($fell(chip_reset_req) |-> pulse_len_ff == RESET_CYCLES)
    else $error("reset pulse length wrong");
  a_pin_tracks_reset: assert property (reset_output_pin_n == !chip_reset_req)
    else $error("reset pin differs from reset pulse");
  a_flag_with_request: assert property ((nmi_req || interval_overflow_request || $rose(chip_reset_req))
    |-> ctrl_ff.overflow_flag)
    else $error("request without overflow flag");
  a_interval_request: assert property (overflow && !ctrl_ff.watchdog_mode_select
    |=> interval_overflow_request && !nmi_req && !chip_reset_req)
    else $error("interval request missing");
  a_watchdog_nmi: assert property (overflow && ctrl_ff.watchdog_mode_select && !ctrl_ff.reset_action_select
    |=> nmi_req && !interval_overflow_request)
    else $error("watchdog NMI missing");
  a_write_wins: assert property (count_wr && !rst_active && !standby_recover
    |=> watchdog_up_counter_ff == $past(wr_byte))
    else $error("counter write lost to increment");
  a_flag_clear_guard: assert property ($fell(ctrl_ff.overflow_flag) && !$past(rst_active)
    && !$past(standby_recover) |-> $past(flag_seen_ff))
    else $error("flag cleared without prior read");
  a_standby_keeps_cks: assert property (standby_recover && !rst_active |=> !ctrl_ff.timer_run_enable
    && ctrl_ff.clock_divider_select == $past(ctrl_ff.clock_divider_select))
    else $error("standby recovery state wrong");
  a_stopped_zero: assert property ($past(!ctrl_ff.timer_run_enable) && !$past(count_wr)
    |-> watchdog_up_counter_ff == CNT_ZERO)
    else $error("stopped counter not zero");
  a_password_reject: assert property (wr_go && !(count_wr || ctrl_wr) |=> bvalid && bresp == RESP_SLVERR)
    else $error("bad write not refused");

  // Requests are single pulses; a stuck one would re-enter the handler
  a_irq_single: assert property (interval_overflow_request |=> !interval_overflow_request)
    else $error("interval request longer than one cycle");
  a_nmi_single: assert property (nmi_req |=> !nmi_req)
    else $error("NMI request longer than one cycle");
  a_nmi_source: assert property (nmi_req
    |-> $past(ctrl_ff.watchdog_mode_select) && $past(ctrl_ff.timer_run_enable))
    else $error("NMI outside watchdog mode");
  a_irq_source: assert property (interval_overflow_request
    |-> !$past(ctrl_ff.watchdog_mode_select) && $past(ctrl_ff.timer_run_enable))
    else $error("interval request outside interval mode");
  a_pulse_indicator: assert property ($rose(chip_reset_req) |-> !external_reset_indicator_ff)
    else $error("reset source not recorded");
  a_pin_release: assert property ($fell(chip_reset_req) |-> reset_output_pin_n)
    else $error("reset pin not released");
  // Counter and control register held cleared while the chip reset lasts
  a_reset_clears: assert property (rst_active
    |=> watchdog_up_counter_ff == CNT_ZERO && ctrl_ff == CTRL_RESET)
    else $error("timer not cleared during reset pulse");
  a_count_step: assert property (ctrl_ff.timer_run_enable && tick && !count_wr
    && !rst_active && !standby_recover |=> watchdog_up_counter_ff == $past(watchdog_up_counter_ff) + 8'h01)
    else $error("counter missed a count pulse");
  a_refused_no_store: assert property (wr_go && !ctrl_wr && !overflow && !rst_active
    && !standby_recover |=> ctrl_ff == $past(ctrl_ff))
    else $error("refused write changed control");
  a_read_arms_clear: assert property (arvalid && arready_ff && rd_index == CTRL_INDEX
    && ctrl_ff.overflow_flag |=> flag_seen_ff)
    else $error("flag read did not arm clear");

endmodule
`default_nettype wire

// File: verif/cpu_side_model.sv
/*
  Far-side model of the CPU core: takes the timer's reset and NMI requests.
  Assumes every watched output is a register on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic chip_reset_req,
  input wire logic reset_output_pin_n,
  input wire logic nmi_req,
  output var int reset_len,
  output var int nmi_seen,
  output var int pin_bad
);
  int run_len;
  // Pin only observed here, never looped back into reset_n
  // Guard words against runaway live in program memory, outside this timer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_len <= 0;
      reset_len <= 0;
      nmi_seen <= 0;
      pin_bad <= 0;
    end else begin
      // One vector whatever the NMI source
      if (nmi_req === 1'b1) nmi_seen <= nmi_seen + 1;
      // Reset request enters the reset vector; its length is kept
      if (chip_reset_req === 1'b1) run_len <= run_len + 1;
      else run_len <= 0;
      if (chip_reset_req === 1'b0 && run_len != 0) reset_len <= run_len;
      // Pin low exactly while the internal reset lasts
      if (reset_output_pin_n !== ~chip_reset_req) pin_bad <= pin_bad + 1;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/*
  Self-checking bench for the watchdog/interval timer over AXI4-Lite.
  Assumes the slave answers within 100 cycles; default divider is /2.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic standby_recover = 0, awready, wready, bvalid, arready, rvalid;
  logic chip_reset_req, reset_output_pin_n, nmi_req, interval_overflow_request;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rd;
  int errors = 0, checks = 0, cyc, reset_len, nmi_seen, pin_bad;
  localparam logic [17:0] CTRL_A = 18'h3fea0, CNT_A = 18'h3fea4, STAT_A = 18'h3fea8, BAD_A = 18'h00010;
  always #4 clk_sys = ~clk_sys;
  watchdog_interval_timer DUT (.clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .standby_recover(standby_recover),
    .chip_reset_req(chip_reset_req), .reset_output_pin_n(reset_output_pin_n), .nmi_req(nmi_req),
    .interval_overflow_request(interval_overflow_request));
  cpu_side_model partner (.clk_sys(clk_sys), .reset_n(reset_n), .chip_reset_req(chip_reset_req),
    .reset_output_pin_n(reset_output_pin_n), .nmi_req(nmi_req), .reset_len(reset_len),
    .nmi_seen(nmi_seen), .pin_bad(pin_bad));
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d errors", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up(input string what);
    errors++;
    $display("BAD %s expected answer seen none", what);
    end_of_test();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [17:0] a, input logic [15:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 100 && bvalid !== 1'b1; n++) begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end
    if (n == 100) give_up("write response");
    r = bresp;
    bready <= 0;
  endtask
  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 100 && rvalid !== 1'b1; n++) begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 0;
    end
    if (n == 100) give_up("read response");
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic rd_chk(input string what, input logic [17:0] a, input logic [7:0] exp);
    axi_rd(a, rd, resp);
    chk(what, {24'h000000, exp}, rd);
  endtask
  // Edges until the chosen request is seen high, or for 3 until the reset request is seen low
  task automatic wait_req(input int which, input int limit, output int n);
    for (n = 1; n <= limit; n++) begin
      @(posedge clk_sys);
      if ((which == 0 ? interval_overflow_request : which == 1 ? nmi_req :
           which == 2 ? chip_reset_req : !chip_reset_req) === 1'b1) return;
    end
    give_up("request");
  endtask
  task automatic t_reset_map();
    rd_chk("ctrl reset", CTRL_A, 8'h10);
    rd_chk("counter reset", CNT_A, 8'h00);
    rd_chk("indicator reset", STAT_A, 8'h08);
    axi_rd(BAD_A, rd, resp);
    chk("unmapped resp", 2'h2, resp);
    axi_wr(CTRL_A, 16'h3320, resp);
    chk("bad password", 2'h2, resp);
    axi_wr(CNT_A, 16'ha520, resp);
    chk("wrong index", 2'h2, resp);
    rd_chk("ctrl untouched", CTRL_A, 8'h10);
    $display("test reset_map done");
  endtask
  task automatic t_interval();
    axi_wr(CTRL_A, 16'ha520, resp);
    wait_req(0, 600, cyc);
    wait_req(0, 600, cyc);
    chk("interval period", 512, cyc);
    // Stopped first, so no new overflow can race the flag checks
    axi_wr(CTRL_A, 16'ha500, resp);
    rd_chk("flag needs read", CTRL_A, 8'h90);
    axi_wr(CTRL_A, 16'ha580, resp);
    rd_chk("write one no effect", CTRL_A, 8'h90);
    axi_wr(CTRL_A, 16'ha500, resp);
    rd_chk("flag cleared", CTRL_A, 8'h10);
    $display("test interval done");
  endtask
  task automatic t_counter_write();
    axi_wr(CTRL_A, 16'ha527, resp);
    axi_wr(CTRL_A, 16'h5a40, resp);
    chk("counter write resp", 2'h0, resp);
    rd_chk("counter stored", CNT_A, 8'h40);
    axi_wr(CTRL_A, 16'ha500, resp);
    $display("test counter_write done");
  endtask
  task automatic t_wd_nmi();
    axi_wr(CTRL_A, 16'ha560, resp);
    wait_req(1, 600, cyc);
    repeat (2) @(posedge clk_sys);
    chk("nmi entries", 1, nmi_seen);
    chk("no reset on nmi", 1'b0, chip_reset_req);
    rd_chk("flag with nmi", CTRL_A, 8'hf0);
    axi_wr(CTRL_A, 16'ha500, resp);
    $display("test wd_nmi done");
  endtask
  task automatic t_wd_reset();
    axi_wr(CTRL_A, 16'ha568, resp);
    repeat (3) begin
      axi_wr(CTRL_A, 16'h5a00, resp);
      repeat (300) @(posedge clk_sys);
    end
    chk("kicked no reset", 1'b0, chip_reset_req);
    wait_req(2, 600, cyc);
    wait_req(3, 600, cyc);
    repeat (2) @(posedge clk_sys);
    chk("reset pulse len", 518, reset_len);
    chk("pin follows reset", 0, pin_bad);
    rd_chk("indicator internal", STAT_A, 8'h00);
    rd_chk("ctrl after reset", CTRL_A, 8'h10);
    $display("test wd_reset done");
  endtask
  task automatic t_standby();
    axi_wr(CTRL_A, 16'ha523, resp);
    @(posedge clk_sys);
    standby_recover <= 1;
    @(posedge clk_sys);
    standby_recover <= 0;
    rd_chk("standby ctrl", CTRL_A, 8'h13);
    rd_chk("standby counter", CNT_A, 8'h00);
    $display("test standby done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1;
    t_reset_map();
    t_interval();
    t_counter_write();
    t_wd_nmi();
    t_wd_reset();
    t_standby();
    end_of_test();
  end
  initial begin
    #800000;
    give_up("run time");
  end
endmodule
`default_nettype wire
